// [rtl/spsg_pkg.sv]
// Function
// - threading and positioning only once synchronized
// - rotation start syncs on next mark pulse
// - zero equals shift plus correction minus set
// - sync loads set position then applies shift
// - jog key runs spindle and syncs likewise
// - above encoder limit drop synchronized state
// - below resync threshold resync on next mark
// - motor encoder gear change forces resync
// - five stages; change disabled by enable bit
// - auto select needs speed mode, else alarm
// - different fixed stage raises change request, code
// - clamp speed to stage limits, set flags
// - auto tests current, then stages one upward
// - stage change only stationary; stop internally; the set still switches on acknowledge without a standstill check
// - hold next block until change completes
// - on acknowledge end oscillation, switch set, accelerate
// - clear request and hold; plc drops acknowledge
// - codes 000/001 set one, up to five
// - each set holds its own speed data
// - axis mode uses parameter set zero
package spsg_pkg;
  localparam int unsigned SPD_W = 16;
  localparam int unsigned PAW   = 6;
  // register byte offsets
  localparam logic [8:0] OFS_CTRL     = 9'h000;
  localparam logic [8:0] OFS_SPEED    = 9'h004;
  localparam logic [8:0] OFS_STAGE    = 9'h008;
  localparam logic [8:0] OFS_PLC      = 9'h00C;
  localparam logic [8:0] OFS_STATUS   = 9'h010;
  localparam logic [8:0] OFS_SETPOINT = 9'h014;
  localparam logic [8:0] OFS_ZERO     = 9'h018;
  localparam logic [8:0] OFS_SHIFT    = 9'h01C;
  localparam logic [8:0] OFS_CORR     = 9'h020;
  localparam logic [8:0] OFS_SETPOS   = 9'h024;
  localparam logic [8:0] OFS_ENCLIM   = 9'h028;
  localparam logic [8:0] OFS_RESYNC   = 9'h02C;
  localparam logic [8:0] OFS_PARAM    = 9'h100;
  // control bits
  localparam int unsigned CTRL_CW     = 0;
  localparam int unsigned CTRL_CCW    = 1;
  localparam int unsigned CTRL_JOG    = 2;
  localparam int unsigned CTRL_AXIS   = 3;
  localparam int unsigned CTRL_GCE    = 4;
  localparam int unsigned CTRL_MOTENC = 5;
  localparam int unsigned CTRL_SPDCTL = 6;
  localparam int unsigned CTRL_SWITCH = 7;
  // plc input bits
  localparam int unsigned PLC_ACK = 3;
  localparam int unsigned PLC_OSC = 4;
  // status bits
  localparam int unsigned ST_SYNC    = 0;
  localparam int unsigned ST_OVER    = 1;
  localparam int unsigned ST_CHG     = 2;
  localparam int unsigned ST_REQ     = 3;
  localparam int unsigned ST_LIM     = 6;
  localparam int unsigned ST_INC     = 7;
  localparam int unsigned ST_HOLD    = 8;
  localparam int unsigned ST_ALARM   = 9;
  localparam int unsigned ST_SET     = 10;
  localparam int unsigned ST_OSC     = 13;
  localparam int unsigned ST_BUSY    = 14;
  // reset values
  localparam logic [7:0]       CTRL_RST   = 8'h50;
  localparam logic [SPD_W-1:0] SETPOS_RST = 16'h0000;
  localparam logic [SPD_W-1:0] ENCLIM_RST = 16'hFFFF;
  localparam logic [6:0]       RESYNC_RST = 7'h5A;
  localparam logic [2:0]       SET_RST    = 3'h1;
  localparam logic [7:0]       PCT_DIV    = 8'h64;
  // parameter set fields
  localparam logic [2:0] FLD_SEL_MAX = 3'h0;
  localparam logic [2:0] FLD_SEL_MIN = 3'h1;
  localparam logic [2:0] FLD_LIM_MAX = 3'h2;
  localparam logic [2:0] FLD_LIM_MIN = 3'h3;
  localparam logic [2:0] NUM_STAGES  = 3'h5;
  localparam logic [2:0] STAGE_AUTO  = 3'h0;
  localparam logic [2:0] SET_NONE    = 3'h7;

  typedef enum logic [2:0] {EV_IDLE, EV_RD_MAX, EV_RD_MIN, EV_CHK,
                            EV_LIM_MAX, EV_LIM_MIN, EV_CLAMP} spsg_eval_e;

  function automatic logic [2:0] spsg_set_of_code(input logic [2:0] code);
    if (code <= 3'h1)
      spsg_set_of_code = 3'h1;
    else if (code <= NUM_STAGES)
      spsg_set_of_code = code;
    else
      spsg_set_of_code = SET_NONE;
  endfunction
endpackage

// [rtl/spsg_pmem_if.sv]
`timescale 1ns/100ps
interface spsg_pmem_if #(parameter int AW = 6, parameter int DW = 16);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [rtl/spsg_param_mem.sv]
`timescale 1ns/100ps
module spsg_param_mem
  import spsg_pkg::*;
#(
  parameter int AW = 6,
  parameter int DW = 16
)(
  input wire logic core_clk,
  spsg_pmem_if.mem pm
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // one read per cycle, data one edge after the address
  always_ff @(posedge core_clk)
  begin
    if (pm.we)
    begin
      mem[pm.waddr] <= pm.wdata;
    end
    pm.rdata <= mem[pm.raddr];
  end
endmodule

// [rtl/spsg_top.sv]
`timescale 1ns/100ps
module spsg_top
  import spsg_pkg::*;
#(
  parameter int SW = SPD_W
)(
  input  wire logic          core_clk,
  input  wire logic          resetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire logic          zero_mark,
  input  wire logic          switch_pulse,
  input  wire logic [SW-1:0] actual_speed,
  input  wire logic          standstill,
  output logic [SW-1:0]      speed_setpoint,
  output logic               synchronized,
  output logic               thread_pos_allowed,
  output logic               change_gear,
  output logic [2:0]         req_stage,
  output logic               block_hold,
  output logic               oscillate,
  output logic [2:0]         param_set
);
  spsg_pmem_if #(.AW(PAW), .DW(SW)) pm ();

  spsg_param_mem #(.AW(PAW), .DW(SW)) u_mem
  (
    .core_clk (core_clk),
    .pm       (pm)
  );

  // bus state
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [8:0] addr_q;
  logic [31:0] rd_mux;
  // software registers
  logic [7:0]    ctrl_q;
  logic [SW-1:0] prog_speed_q;
  logic [2:0]    stage_cmd_q;
  logic [4:0]    plc_q;
  logic [SW-1:0] shift_q;
  logic [SW-1:0] corr_q;
  logic [SW-1:0] setpos_q;
  logic [SW-1:0] enclim_q;
  logic [6:0]    resync_q;
  // block state
  logic          sync_q;
  logic          over_q;
  logic [SW-1:0] zero_q;
  logic          chg_q;
  logic [2:0]    req_q;
  logic          hold_q;
  logic          osc_q;
  logic [2:0]    act_set_q;
  logic          alarm_q;
  logic          lim_q;
  logic          inc_q;
  logic [SW-1:0] clamp_q;
  logic [SW-1:0] setpt_q;
  spsg_eval_e    ev_q;
  logic [2:0]    scan_q;
  logic          first_q;
  logic [2:0]    target_q;
  logic [SW-1:0] sel_max_q;
  logic [SW-1:0] lim_max_q;

  wire addr_ok   = hsel && hready && htrans[1];
  wire wr_now    = wr_pend_q;
  wire wr_ctrl   = wr_now && (addr_q == OFS_CTRL);
  wire wr_speed  = wr_now && (addr_q == OFS_SPEED);
  wire wr_stage  = wr_now && (addr_q == OFS_STAGE);
  wire wr_plc    = wr_now && (addr_q == OFS_PLC);
  wire wr_status = wr_now && (addr_q == OFS_STATUS);
  wire wr_shift  = wr_now && (addr_q == OFS_SHIFT);
  wire wr_corr   = wr_now && (addr_q == OFS_CORR);
  wire wr_setpos = wr_now && (addr_q == OFS_SETPOS);
  wire wr_enclim = wr_now && (addr_q == OFS_ENCLIM);
  wire wr_resync = wr_now && (addr_q == OFS_RESYNC);
  wire wr_param  = wr_now && addr_q[8] && (addr_q[7:5] <= NUM_STAGES);

  wire axis_mode = ctrl_q[CTRL_AXIS];
  wire gce       = ctrl_q[CTRL_GCE];
  wire rotating  = ctrl_q[CTRL_CW] || ctrl_q[CTRL_CCW] || ctrl_q[CTRL_JOG];
  wire sync_src  = ctrl_q[CTRL_SWITCH] ? switch_pulse : zero_mark;
  wire [2:0] act_code = plc_q[2:0];
  wire [2:0] new_set  = spsg_set_of_code(act_code);
  wire [2:0] cur_stg  = (act_set_q == 3'h0) ? SET_RST : act_set_q;

  // a speed write re-runs the last stage command, like a new S value
  wire [2:0] cmd_now  = wr_stage ? hwdata[2:0] : stage_cmd_q;
  wire ev_start  = (wr_stage || wr_speed) && (ev_q == EV_IDLE) && !axis_mode;
  wire auto_bad  = ev_start && (cmd_now == STAGE_AUTO) && !ctrl_q[CTRL_SPDCTL];
  wire cmd_fixed = (cmd_now != STAGE_AUTO) && (cmd_now <= NUM_STAGES);

  // encoder frequency supervision
  wire [SW+6:0]  thr_prod  = enclim_q * resync_q;
  wire [SW+6:0]  thr_div   = thr_prod / PCT_DIV;
  wire [SW-1:0]  resync_thr = thr_div[SW-1:0];
  wire over_set  = actual_speed > enclim_q;
  wire over_clr  = actual_speed < resync_thr;

  // handshake completion, invalid codes never complete
  wire ack_ok    = chg_q && plc_q[PLC_ACK] && (new_set != SET_NONE);
  wire sel_pass  = (prog_speed_q <= sel_max_q) && (prog_speed_q >= pm.rdata);
  wire [SW-1:0] clamped = (prog_speed_q > lim_max_q) ? lim_max_q :
                          (prog_speed_q < pm.rdata) ? pm.rdata : prog_speed_q;

  // memory access: bus writes on the write port, evaluation on the read port
  assign pm.we    = wr_param;
  assign pm.waddr = addr_q[7:2];
  assign pm.wdata = hwdata[SW-1:0];
  assign pm.raddr = (ev_q == EV_RD_MAX || ev_q == EV_IDLE) ? {scan_q, FLD_SEL_MAX} :
                    (ev_q == EV_RD_MIN) ? {scan_q, FLD_SEL_MIN} :
                    (ev_q == EV_LIM_MAX) ? {target_q, FLD_LIM_MAX} :
                    {target_q, FLD_LIM_MIN};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_q == OFS_CTRL)
      rd_mux[7:0] = ctrl_q;
    else if (addr_q == OFS_SPEED)
      rd_mux[SW-1:0] = prog_speed_q;
    else if (addr_q == OFS_STAGE)
      rd_mux[2:0] = stage_cmd_q;
    else if (addr_q == OFS_PLC)
      rd_mux[4:0] = plc_q;
    else if (addr_q == OFS_STATUS)
    begin
      rd_mux[ST_SYNC]          = sync_q;
      rd_mux[ST_OVER]          = over_q;
      rd_mux[ST_CHG]           = chg_q;
      rd_mux[ST_REQ+:3]        = req_q;
      rd_mux[ST_LIM]           = lim_q;
      rd_mux[ST_INC]           = inc_q;
      rd_mux[ST_HOLD]          = hold_q;
      rd_mux[ST_ALARM]         = alarm_q;
      rd_mux[ST_SET+:3]        = axis_mode ? 3'h0 : act_set_q;
      rd_mux[ST_OSC]           = osc_q;
      rd_mux[ST_BUSY]          = ev_q != EV_IDLE;
    end
    else if (addr_q == OFS_SETPOINT)
      rd_mux[SW-1:0] = setpt_q;
    else if (addr_q == OFS_ZERO)
      rd_mux[SW-1:0] = zero_q;
    else if (addr_q == OFS_SHIFT)
      rd_mux[SW-1:0] = shift_q;
    else if (addr_q == OFS_CORR)
      rd_mux[SW-1:0] = corr_q;
    else if (addr_q == OFS_SETPOS)
      rd_mux[SW-1:0] = setpos_q;
    else if (addr_q == OFS_ENCLIM)
      rd_mux[SW-1:0] = enclim_q;
    else if (addr_q == OFS_RESYNC)
      rd_mux[6:0] = resync_q;
  end

  // bus slave: zero wait states, read data registered into the data phase
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 9'h000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok)
        addr_q <= haddr[8:0];
      if (rd_pend_q)
        hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite)
        hrdata <= rd_next(haddr[8:0]);
    end
  end

  // read mux is indexed by the registered address; peek at the new one
  function automatic logic [31:0] rd_next(input logic [8:0] a);
    rd_next = (a == addr_q) ? rd_mux : rd_mux_at(a);
  endfunction

  function automatic logic [31:0] rd_mux_at(input logic [8:0] a);
    rd_mux_at = 32'h0000_0000;
    if (a == OFS_CTRL)
      rd_mux_at[7:0] = ctrl_q;
    else if (a == OFS_SPEED)
      rd_mux_at[SW-1:0] = prog_speed_q;
    else if (a == OFS_STAGE)
      rd_mux_at[2:0] = stage_cmd_q;
    else if (a == OFS_PLC)
      rd_mux_at[4:0] = plc_q;
    else if (a == OFS_STATUS)
      rd_mux_at[15:0] = {1'b0, ev_q != EV_IDLE, osc_q, axis_mode ? 3'h0 : act_set_q,
                         alarm_q, hold_q, inc_q, lim_q, req_q, chg_q, over_q, sync_q};
    else if (a == OFS_SETPOINT)
      rd_mux_at[SW-1:0] = setpt_q;
    else if (a == OFS_ZERO)
      rd_mux_at[SW-1:0] = zero_q;
    else if (a == OFS_SHIFT)
      rd_mux_at[SW-1:0] = shift_q;
    else if (a == OFS_CORR)
      rd_mux_at[SW-1:0] = corr_q;
    else if (a == OFS_SETPOS)
      rd_mux_at[SW-1:0] = setpos_q;
    else if (a == OFS_ENCLIM)
      rd_mux_at[SW-1:0] = enclim_q;
    else if (a == OFS_RESYNC)
      rd_mux_at[6:0] = resync_q;
  endfunction

  // software registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q       <= CTRL_RST;
      prog_speed_q <= '0;
      stage_cmd_q  <= STAGE_AUTO;
      plc_q        <= 5'h00;
      shift_q      <= '0;
      corr_q       <= '0;
      setpos_q     <= SETPOS_RST;
      enclim_q     <= ENCLIM_RST;
      resync_q     <= RESYNC_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= hwdata[7:0];
      if (wr_speed)
        prog_speed_q <= hwdata[SW-1:0];
      if (wr_stage)
        stage_cmd_q <= hwdata[2:0];
      if (wr_plc)
        plc_q <= hwdata[4:0];
      if (wr_shift)
        shift_q <= hwdata[SW-1:0];
      if (wr_corr)
        corr_q <= hwdata[SW-1:0];
      if (wr_setpos)
        setpos_q <= hwdata[SW-1:0];
      if (wr_enclim)
        enclim_q <= hwdata[SW-1:0];
      if (wr_resync)
        resync_q <= hwdata[6:0];
    end
  end

  // synchronization with the measuring system
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_q <= 1'b0;
      over_q <= 1'b0;
      zero_q <= '0;
    end
    else
    begin
      if (over_set)
        over_q <= 1'b1;
      else if (over_clr)
        over_q <= 1'b0;
      if (over_set)
        sync_q <= 1'b0;
      else if (ack_ok && ctrl_q[CTRL_MOTENC])
        sync_q <= 1'b0;
      else if (!sync_q && !over_q && rotating && !chg_q && sync_src)
      begin
        sync_q <= 1'b1;
        zero_q <= SW'(shift_q + corr_q - setpos_q);
      end
    end
  end

  // stage evaluation: current stage first, then one upward, then clamp
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_q      <= EV_IDLE;
      scan_q    <= SET_RST;
      first_q   <= 1'b0;
      target_q  <= SET_RST;
      sel_max_q <= '0;
      lim_max_q <= '0;
      clamp_q   <= '0;
      lim_q     <= 1'b0;
      inc_q     <= 1'b0;
    end
    else
    begin
      case (ev_q)
        EV_IDLE:
        begin
          if (ev_start && !auto_bad && cmd_fixed)
          begin
            target_q <= gce ? cmd_now : cur_stg;
            ev_q     <= EV_LIM_MAX;
          end
          else if (ev_start && !auto_bad && cmd_now == STAGE_AUTO)
          begin
            scan_q  <= cur_stg;
            first_q <= 1'b1;
            ev_q    <= EV_RD_MAX;
          end
        end
        EV_RD_MAX:
          ev_q <= EV_RD_MIN;
        EV_RD_MIN:
        begin
          sel_max_q <= pm.rdata;
          ev_q      <= EV_CHK;
        end
        EV_CHK:
        begin
          if (sel_pass && gce)
          begin
            target_q <= scan_q;
            ev_q     <= EV_LIM_MAX;
          end
          else if (first_q && gce)
          begin
            scan_q  <= SET_RST;
            first_q <= 1'b0;
            ev_q    <= EV_RD_MAX;
          end
          else if (scan_q >= NUM_STAGES || !gce)
          begin
            target_q <= cur_stg;
            ev_q     <= EV_LIM_MAX;
          end
          else
          begin
            scan_q <= scan_q + 3'h1;
            ev_q   <= EV_RD_MAX;
          end
        end
        EV_LIM_MAX:
          ev_q <= EV_LIM_MIN;
        EV_LIM_MIN:
        begin
          lim_max_q <= pm.rdata;
          ev_q      <= EV_CLAMP;
        end
        EV_CLAMP:
        begin
          clamp_q <= clamped;
          lim_q   <= prog_speed_q > lim_max_q;
          inc_q   <= (prog_speed_q <= lim_max_q) && (prog_speed_q < pm.rdata);
          ev_q    <= EV_IDLE;
        end
        default:
          ev_q <= EV_IDLE;
      endcase
    end
  end

  // gear change handshake with the plc
  wire chg_start = (ev_q == EV_CLAMP) && gce && !chg_q && (target_q != cur_stg);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chg_q     <= 1'b0;
      req_q     <= SET_RST;
      hold_q    <= 1'b0;
      osc_q     <= 1'b0;
      act_set_q <= SET_RST;
      alarm_q   <= 1'b0;
    end
    else
    begin
      if (chg_start)
      begin
        chg_q  <= 1'b1;
        req_q  <= target_q;
        hold_q <= 1'b1;
      end
      else if (ack_ok)
      begin
        chg_q     <= 1'b0;
        hold_q    <= 1'b0;
        act_set_q <= new_set;
      end
      // oscillation only while stationary inside an open change
      osc_q <= chg_q && !ack_ok && plc_q[PLC_OSC] && standstill;
      // a raised alarm survives a clear in the same cycle
      if (auto_bad)
        alarm_q <= 1'b1;
      else if (wr_status && hwdata[ST_ALARM])
        alarm_q <= 1'b0;
    end
  end

  // setpoint: internal stop during a change, last speed afterwards
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      setpt_q <= '0;
    end
    else
    begin
      setpt_q <= (rotating && !chg_q && !axis_mode) ? clamp_q : '0;
    end
  end

  // outputs, all from flip-flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      speed_setpoint     <= '0;
      synchronized       <= 1'b0;
      thread_pos_allowed <= 1'b0;
      change_gear        <= 1'b0;
      req_stage          <= SET_RST;
      block_hold         <= 1'b0;
      oscillate          <= 1'b0;
      param_set          <= SET_RST;
    end
    else
    begin
      speed_setpoint     <= setpt_q;
      synchronized       <= sync_q;
      thread_pos_allowed <= sync_q;
      change_gear        <= chg_q;
      req_stage          <= req_q;
      block_hold         <= hold_q;
      oscillate          <= osc_q;
      param_set          <= axis_mode ? 3'h0 : act_set_q;
    end
  end
endmodule

// [tb/spsg_chk_sva.sv]
`timescale 1ns/100ps
module spsg_chk
  import spsg_pkg::*;
#(
  parameter int SW = SPD_W
)(
  input wire logic          core_clk,
  input wire logic          resetn,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          zero_mark,
  input wire logic          switch_pulse,
  input wire logic [SW-1:0] speed_setpoint,
  input wire logic          synchronized,
  input wire logic          thread_pos_allowed,
  input wire logic          change_gear,
  input wire logic [2:0]    req_stage,
  input wire logic          block_hold,
  input wire logic          oscillate,
  input wire logic [2:0]    param_set
);
  // either sync source; the design picks one, so both are accepted here
  wire logic src = zero_mark | switch_pulse;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  pos_gate_a: assert property (thread_pos_allowed == synchronized)
    else $error("position gate differs from sync");
  sync_src_a: assert property ($rose(synchronized) |->
    $past(src, 2) || $past(src, 3) || $past(src, 4))
    else $error("sync without a mark pulse");
  stage_code_a: assert property (req_stage inside {[3'h1:3'h5]})
    else $error("requested stage out of range");
  set_range_a: assert property (param_set <= 3'h5)
    else $error("parameter set out of range");
  hold_req_a: assert property (change_gear |-> block_hold)
    else $error("change pending without block hold");
  stop_chg_a: assert property (change_gear && $past(change_gear) |->
    speed_setpoint == '0)
    else $error("setpoint not zero during change");
  osc_chg_a: assert property (oscillate |-> change_gear)
    else $error("oscillation outside a change");
  release_a: assert property ($fell(change_gear) |-> !block_hold && !oscillate)
    else $error("hold or oscillation kept after change");
  bus_ok_a: assert property ($past(resetn) |-> !hresp && hreadyout)
    else $error("bus response not okay or stalled");
endmodule

bind spsg_top spsg_chk #(.SW(SW)) chk_i (.core_clk(core_clk), .resetn(resetn),
  .hreadyout(hreadyout), .hresp(hresp), .zero_mark(zero_mark),
  .switch_pulse(switch_pulse), .speed_setpoint(speed_setpoint),
  .synchronized(synchronized), .thread_pos_allowed(thread_pos_allowed),
  .change_gear(change_gear), .req_stage(req_stage), .block_hold(block_hold),
  .oscillate(oscillate), .param_set(param_set));

// [tb/spsg_plc_enc.sv]
`timescale 1ns/100ps
module spsg_plc_enc
  import spsg_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [SPD_W-1:0] speed_cmd,
  output logic                  zero_mark,
  output logic                  switch_pulse,
  output logic [SPD_W-1:0]      actual_speed,
  output logic                  standstill
);
  // a revolution of 16 cycles keeps runs short; no marks while stationary
  logic [3:0] phase_q;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      phase_q <= 4'h0;
      zero_mark <= 1'b0;
      switch_pulse <= 1'b0;
      actual_speed <= '0;
      standstill <= 1'b1;
    end
    else
    begin
      phase_q <= phase_q + 4'h1;
      actual_speed <= speed_cmd;
      standstill <= (speed_cmd == '0);
      // one mark per revolution keeps the marker gap inside two revolutions
      zero_mark <= (speed_cmd != '0) && (phase_q == 4'hF);
      switch_pulse <= (speed_cmd != '0) && (phase_q == 4'h7);
    end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top
  import spsg_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hwrite, hreadyout, hresp, zero_mark, switch_pulse, standstill;
  logic        synchronized, thread_pos_allowed, change_gear, block_hold, oscillate;
  logic [15:0] actual_speed, speed_setpoint, spd;
  logic [2:0]  req_stage, param_set;
  int          failures = 0;
  int          checked = 0;

  always #25 core_clk = ~core_clk;

  spsg_top DUT (.core_clk(core_clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .zero_mark(zero_mark), .switch_pulse(switch_pulse), .actual_speed(actual_speed),
    .standstill(standstill), .speed_setpoint(speed_setpoint),
    .synchronized(synchronized), .thread_pos_allowed(thread_pos_allowed),
    .change_gear(change_gear), .req_stage(req_stage), .block_hold(block_hold),
    .oscillate(oscillate), .param_set(param_set));

  spsg_plc_enc PM (.core_clk(core_clk), .resetn(resetn), .speed_cmd(spd),
    .zero_mark(zero_mark), .switch_pulse(switch_pulse),
    .actual_speed(actual_speed), .standstill(standstill));

  task automatic final_report;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait on a level; a stuck design ends the run instead of hanging
  task automatic wait_hi(input bit ready_wait);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while ((ready_wait ? hreadyout : synchronized) !== 1'b1 && n < 200);
    if ((ready_wait ? hreadyout : synchronized) !== 1'b1)
    begin
      failures++;
      final_report;
    end
  endtask

  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {23'h0, a};
    hwrite <= w;
    wait_hi(1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hi(1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (10) @(posedge core_clk);
  endtask

  task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial
  begin
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    spd = 16'h0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(param_set), 32'h1);
    rdc(OFS_CTRL, 32'h50);
    rdc(OFS_ENCLIM, 32'hFFFF);
    rdc(OFS_RESYNC, 32'h5A);
    rdc(OFS_SETPOS, 32'h0);
    rdc(9'h030, 32'h0);
    // stage s selects and limits between (s-1)*1000 and s*1000
    for (int s = 1; s <= 5; s++)
      for (int f = 0; f < 4; f++)
        bus(1'b1, 9'(OFS_PARAM + s * 32 + f * 4), 32'((s - (f & 1)) * 1000));
    bus(1'b1, OFS_SHIFT, 32'h100);
    bus(1'b1, OFS_CORR, 32'h20);
    bus(1'b1, OFS_SETPOS, 32'h10);
    bus(1'b1, OFS_ENCLIM, 32'h7D0);
    bus(1'b1, OFS_CTRL, 32'h71);
    wr(OFS_STAGE, 32'h1);
    spd <= 16'h4B0;
    wr(OFS_SPEED, 32'h5DC);
    chk(32'(speed_setpoint), 32'h3E8);
    chk(32'(change_gear), 32'h0);
    // sync depends on where the mark falls, so it is masked here
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'hFFFF_FFFE, 32'h0000_0448);
    chk(32'(rd[ST_LIM]), 32'h1);
    wait_hi(1'b0);
    rdc(OFS_ZERO, 32'h110);
    chk(32'(thread_pos_allowed), 32'h1);
    spd <= 16'h9C4;
    repeat (8) @(posedge core_clk);
    chk(32'(synchronized), 32'h0);
    spd <= 16'h76C;
    repeat (40) @(posedge core_clk);
    chk(32'(synchronized), 32'h0);
    spd <= 16'h3E8;
    wait_hi(1'b0);
    spd <= 16'h0;
    wr(OFS_SPEED, 32'h1F4);
    wr(OFS_STAGE, 32'h2);
    chk(32'(change_gear), 32'h1);
    chk(32'(req_stage), 32'h2);
    chk(32'(block_hold), 32'h1);
    chk(32'(speed_setpoint), 32'h0);
    wr(OFS_PLC, 32'h10);
    chk(32'(oscillate), 32'h1);
    wr(OFS_PLC, 32'h1E);
    chk(32'(change_gear), 32'h1);
    chk(32'(param_set), 32'h1);
    bus(1'b1, OFS_PLC, 32'h12);
    wr(OFS_PLC, 32'h1A);
    chk(32'(change_gear), 32'h0);
    chk(32'(block_hold), 32'h0);
    chk(32'(oscillate), 32'h0);
    chk(32'(param_set), 32'h2);
    chk(32'(synchronized), 32'h0);
    chk(32'(speed_setpoint), 32'h3E8);
    wr(OFS_PLC, 32'h2);
    wr(OFS_CTRL, 32'h74);
    spd <= 16'h320;
    wait_hi(1'b0);
    wr(OFS_CTRL, 32'h61);
    wr(OFS_STAGE, 32'h3);
    chk(32'(change_gear), 32'h0);
    wr(OFS_CTRL, 32'h31);
    wr(OFS_STAGE, 32'h0);
    chk(32'(change_gear), 32'h0);
    rdc(OFS_STATUS, 32'h0000_0A91);
    chk(32'(rd[ST_ALARM]), 32'h1);
    wr(OFS_CTRL, 32'h71);
    wr(OFS_SPEED, 32'hDAC);
    repeat (20) @(posedge core_clk);
    chk(32'(change_gear), 32'h1);
    chk(32'(req_stage), 32'h4);
    wr(OFS_CTRL, 32'h79);
    chk(32'(param_set), 32'h0);
    final_report;
  end
endmodule
